// ### rtl/cpwrb_pkg.sv
// Purpose: Shared constants and carrier types of the chopper and PWM register bank
// Assumes: Word indices are multiplied by four to form AXI byte addresses
// Notes:   Field positions of the readback words are listed here; the bank builds those words with fixed concatenations
`default_nettype none
package cpwrb_pkg;
  // Bus geometry
  localparam int          ADDR_W       = 10;
  localparam int          IDX_W        = 8;
  // Register word indices
  localparam logic [7:0]  IDX_CHOP     = 8'h6C;
  localparam logic [7:0]  IDX_DRVST    = 8'h6F;
  localparam logic [7:0]  IDX_PWMC     = 8'h70;
  localparam logic [7:0]  IDX_SCALE    = 8'h71;
  localparam logic [7:0]  IDX_AUTO     = 8'h72;
  localparam logic [7:0]  IDX_IRQST    = 8'h73;
  localparam logic [7:0]  IDX_IRQMSK   = 8'h74;
  // Reset values
  localparam logic [31:0] CHOP_RST     = 32'h10000053;
  localparam logic [31:0] PWMC_RST     = 32'hC10D0024;
  localparam logic [21:0] PWMC_MASK    = 22'h3FFFFF;
  // Field positions
  localparam int          PWMC_OFS_LSB = 0;
  localparam int          PWMC_GRD_LSB = 8;
  localparam int          SCALE_OFS_LSB = 16;
  localparam int          AUTO_GRD_LSB = 16;
  localparam int          STAT_LVL_LSB = 16;
  // Value limits
  localparam logic [7:0]  DUTY_MAX     = 8'hFF;
  localparam logic signed [8:0] OFS_MAX = 9'sh0FF;
  localparam logic signed [8:0] OFS_MIN = -9'sh0FF;
  localparam logic [9:0]  PHASE_B_SHIFT = 10'h100;
  // Interrupt bit positions
  localparam int          IRQ_W        = 3;
  localparam int          IRQ_CLIP     = 0;
  localparam int          IRQ_SAT      = 1;
  localparam int          IRQ_FLAG     = 2;
  // AXI responses
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // Motor side inputs from the sequencer and current sensing logic
  typedef struct packed {
    logic [7:0]  meas_current;   // Measured coil current amplitude
    logic [7:0]  target_current; // Wanted coil current amplitude
    logic [7:0]  velocity;       // Present step rate, scaled
    logic [9:0]  microstep_position_counter; // Position in the wave
    logic [15:0] drv_flags;      // Raw driver status flags
    logic        standstill;     // Motor at rest
    logic        reg_strobe;     // One regulation tick
  } cpwrb_motor_in_t;

  // Scaled phase currents
  typedef struct packed {
    logic signed [8:0] phase_a;  // Phase A drive value
    logic signed [8:0] phase_b;  // Phase B drive value
  } cpwrb_phase_t;
endpackage
`default_nettype wire

// ### rtl/cpwrb_phase_scaler.sv
// Purpose: Looks up both phase currents in the wave table and scales them by duty
// Assumes: Position and duty come from logic on REF_CLK
// Notes:   Quarter wave is a parabolic fit held as a function, one cycle latency
`default_nettype none
module cpwrb_phase_scaler
  import cpwrb_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic [9:0]             position,
  input  wire logic [7:0]             duty,
  output cpwrb_pkg::cpwrb_phase_t     phase_q
);
  // Wave table: four quadrants of a parabolic quarter wave
  function automatic logic signed [8:0] wave_at(input logic [9:0] p);
    logic [7:0]  x;
    logic [7:0]  nx;
    logic [15:0] sq;
    logic [7:0]  r;
    x  = p[8] ? ~p[7:0] : p[7:0];
    // Invert at 8 bits first, a widening cast would fill the top byte with ones
    nx = ~x;
    sq = 16'(nx) * 16'(nx);
    r  = DUTY_MAX - sq[15:8];
    wave_at = p[9] ? -$signed({1'b0, r}) : $signed({1'b0, r});
  endfunction

  // Table reads for both phases
  wire logic [9:0]         pos_b  = position + PHASE_B_SHIFT;
  wire logic signed [8:0]  tab_a  = wave_at(position);
  wire logic signed [8:0]  tab_b  = wave_at(pos_b);
  // Duty scaling products
  wire logic signed [17:0] prod_a = tab_a * $signed({1'b0, duty});
  wire logic signed [17:0] prod_b = tab_b * $signed({1'b0, duty});

  // R5: duty scales both phases
  // R10: B read 256 entries ahead
  always_ff @(posedge clk) begin
    if (rst) begin
      phase_q <= '0;
    end else begin
      phase_q.phase_a <= prod_a[16:8];
      phase_q.phase_b <= prod_b[16:8];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_zero_duty_mute: assert property (duty == 8'h00 |=> phase_q == '0) // R5
    else $error("Phase output not muted at zero duty");
  a_phase_b_lead: assert property (position == 10'h000 && duty == DUTY_MAX |=>
    phase_q.phase_b > 9'sh0F0) // R10
    else $error("Phase B not read one quarter ahead");
endmodule
`default_nettype wire

// ### rtl/cpwrb_bank.sv
// Purpose: AXI4-Lite register bank with PWM amplitude regulator and readbacks
// Assumes: Motor side inputs are produced on REF_CLK; RST is synchronous
// Notes:   Byte address is four times the word index
// Summary of operation
// R1: Chopper config RW, reset 0x10000053
// R2: Driver status read-only, flags plus level
// R3: PWM config RW, 22 bits, documented reset
// R4: Low byte reports actual duty cycle
// R5: Duty scales phase A and B currents
// R6: Bits 24:16 hold signed regulation offset
// R7: Offset follows measured current automatically
// R8: Auto offset and gradient readback word
// R9: Host may seed settings from autos
// R10: Phase B reads 256 table entries ahead
// R11: Applied duty is sum clamped 0..255
//
// Local design decision: the AXI4-Lite slave port.
`default_nettype none
module cpwrb_bank
  import cpwrb_pkg::*;
(
  input  wire logic                    REF_CLK,
  input  wire logic                    RST,
  input  wire logic [ADDR_W-1:0]       S_AXI_AWADDR,
  input  wire logic                    S_AXI_AWVALID,
  output logic                         S_AXI_AWREADY,
  input  wire logic [31:0]             S_AXI_WDATA,
  input  wire logic [3:0]              S_AXI_WSTRB,
  input  wire logic                    S_AXI_WVALID,
  output logic                         S_AXI_WREADY,
  output logic [1:0]                   S_AXI_BRESP,
  output logic                         S_AXI_BVALID,
  input  wire logic                    S_AXI_BREADY,
  input  wire logic [ADDR_W-1:0]       S_AXI_ARADDR,
  input  wire logic                    S_AXI_ARVALID,
  output logic                         S_AXI_ARREADY,
  output logic [31:0]                  S_AXI_RDATA,
  output logic [1:0]                   S_AXI_RRESP,
  output logic                         S_AXI_RVALID,
  input  wire logic                    S_AXI_RREADY,
  input  wire cpwrb_pkg::cpwrb_motor_in_t MOTOR_IN,
  output logic [31:0]                  CHOP_CFG,
  output logic [21:0]                  PWM_CFG,
  output logic [7:0]                   DUTY,
  output cpwrb_pkg::cpwrb_phase_t      PHASE_OUT,
  output logic                         IRQ
);
  import cpwrb_pkg::*;

  // Word index from a byte address
  function automatic logic [IDX_W-1:0] idx_of(input logic [ADDR_W-1:0] a);
    idx_of = a[ADDR_W-1:2];
  endfunction

  // Byte lane merge of a write into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    for (int i = 0; i < 4; i++) begin
      merge[8*i +: 8] = st[i] ? nw[8*i +: 8] : old[8*i +: 8];
    end
  endfunction

  // Bus state
  logic                  aw_have_q;   // Write address held
  logic                  w_have_q;    // Write data held
  logic [ADDR_W-1:0]     awaddr_q;    // Held write address
  logic [31:0]           wdata_q;     // Held write data
  logic [3:0]            wstrb_q;     // Held byte strobes
  logic                  bvalid_q;    // Write answer pending
  logic [1:0]            bresp_q;     // Write answer code
  logic                  rvalid_q;    // Read answer pending
  logic [31:0]           rdata_q;     // Read data
  logic [1:0]            rresp_q;     // Read answer code
  // Register state
  logic [31:0]           chop_q;      // Chopper and driver configuration
  logic [31:0]           pwmc_q;      // PWM chopper configuration
  logic [IRQ_W-1:0]      irq_st_q;    // Sticky event bits
  logic [IRQ_W-1:0]      irq_msk_q;   // Interrupt enables
  // Regulator state
  logic signed [8:0]     ofs_q;       // Regulation offset
  logic [7:0]            duty_q;      // Applied duty cycle
  logic [7:0]            auto_ofs_q;  // Auto determined offset
  logic [7:0]            auto_grd_q;  // Auto determined gradient
  logic [15:0]           flags_q;     // Flags seen last cycle

  // Handshakes
  assign S_AXI_AWREADY = !aw_have_q && !bvalid_q;
  assign S_AXI_WREADY  = !w_have_q && !bvalid_q;
  assign S_AXI_ARREADY = !rvalid_q;
  wire logic aw_hs   = S_AXI_AWVALID && S_AXI_AWREADY;
  wire logic w_hs    = S_AXI_WVALID && S_AXI_WREADY;
  wire logic ar_hs   = S_AXI_ARVALID && S_AXI_ARREADY;
  wire logic wr_fire = aw_have_q && w_have_q && !bvalid_q;

  // Write decode
  wire logic [IDX_W-1:0] wr_idx   = idx_of(awaddr_q);
  wire logic wr_chop   = wr_fire && wr_idx == IDX_CHOP;
  wire logic wr_pwmc   = wr_fire && wr_idx == IDX_PWMC;
  wire logic wr_irqst  = wr_fire && wr_idx == IDX_IRQST;
  wire logic wr_irqmsk = wr_fire && wr_idx == IDX_IRQMSK;
  wire logic wr_ro     = wr_idx == IDX_DRVST || wr_idx == IDX_SCALE || wr_idx == IDX_AUTO;
  wire logic wr_known  = wr_ro || wr_idx == IDX_CHOP || wr_idx == IDX_PWMC ||
                         wr_idx == IDX_IRQST || wr_idx == IDX_IRQMSK;
  wire logic [31:0] w1c_bits = merge(32'h00000000, wdata_q, wstrb_q);
  wire logic [31:0] msk_merged = merge({29'h0, irq_msk_q}, wdata_q, wstrb_q); // Mask after lane merge

  // Calculated duty from configured offset and gradient
  wire logic [7:0]  cfg_ofs   = pwmc_q[PWMC_OFS_LSB +: 8];
  wire logic [7:0]  cfg_grd   = pwmc_q[PWMC_GRD_LSB +: 8];
  wire logic [15:0] grd_prod  = 16'(cfg_grd) * 16'(MOTOR_IN.velocity);
  wire logic [8:0]  calc_sum  = 9'(cfg_ofs) + 9'(grd_prod[15:8]);
  wire logic [7:0]  calc_duty = calc_sum[8] ? DUTY_MAX : calc_sum[7:0];
  // R11: Sum and clamp to 0..255
  wire logic signed [10:0] app_sum = $signed({3'b000, calc_duty}) + 11'(ofs_q);
  wire logic clip_lo = app_sum < 0;
  wire logic clip_hi = app_sum > $signed({3'b000, DUTY_MAX});
  wire logic [7:0] applied = clip_lo ? 8'h00 : (clip_hi ? DUTY_MAX : app_sum[7:0]);

  // Regulator step direction
  wire logic want_up  = MOTOR_IN.meas_current < MOTOR_IN.target_current;
  wire logic want_dn  = MOTOR_IN.meas_current > MOTOR_IN.target_current;
  wire logic at_top   = ofs_q == OFS_MAX;
  wire logic at_bot   = ofs_q == OFS_MIN;
  wire logic step_up  = MOTOR_IN.reg_strobe && want_up && !at_top;
  wire logic step_dn  = MOTOR_IN.reg_strobe && want_dn && !at_bot;

  // Events
  wire logic [IRQ_W-1:0] evt;
  assign evt[IRQ_CLIP] = clip_lo || clip_hi;
  assign evt[IRQ_SAT]  = MOTOR_IN.reg_strobe && ((want_up && at_top) || (want_dn && at_bot));
  assign evt[IRQ_FLAG] = |(MOTOR_IN.drv_flags & ~flags_q);

  // Readback words
  wire logic [31:0] drvst_word = {11'h000, duty_q[7:3], MOTOR_IN.drv_flags};
  wire logic [31:0] scale_word = {7'h00, ofs_q, 8'h00, duty_q};
  wire logic [31:0] auto_word  = {8'h00, auto_grd_q, 8'h00, auto_ofs_q};
  wire logic [IDX_W-1:0] rd_idx = idx_of(S_AXI_ARADDR);
  // R2: Status read-only word
  // R4: Duty in the low byte
  // R8: Auto values readback
  wire logic [31:0] rd_word =
    rd_idx == IDX_CHOP   ? chop_q :
    rd_idx == IDX_DRVST  ? drvst_word :
    rd_idx == IDX_PWMC   ? {10'h000, pwmc_q[21:0]} :
    rd_idx == IDX_SCALE  ? scale_word :
    rd_idx == IDX_AUTO   ? auto_word :
    rd_idx == IDX_IRQST  ? {29'h0, irq_st_q} :
    rd_idx == IDX_IRQMSK ? {29'h0, irq_msk_q} : 32'h00000000;
  wire logic rd_known = rd_idx inside {IDX_CHOP, IDX_DRVST, IDX_PWMC, IDX_SCALE,
                                       IDX_AUTO, IDX_IRQST, IDX_IRQMSK};

  // Write channel capture and answer
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end else begin
      if (aw_hs) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= S_AXI_AWADDR;
      end
      if (w_hs) begin
        w_have_q <= 1'b1;
        wdata_q  <= S_AXI_WDATA;
        wstrb_q  <= S_AXI_WSTRB;
      end
      if (wr_fire) begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && S_AXI_BREADY) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Read channel answer
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= RESP_OKAY;
    end else if (ar_hs) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_word;
      rresp_q  <= rd_known ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && S_AXI_RREADY) begin
      rvalid_q <= 1'b0;
    end
  end

  // R1: Chopper config storage
  // R3: PWM config storage
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      chop_q    <= CHOP_RST;
      pwmc_q    <= PWMC_RST;
      irq_msk_q <= '0;
    end else begin
      if (wr_chop)   chop_q    <= merge(chop_q, wdata_q, wstrb_q);
      if (wr_pwmc)   pwmc_q    <= merge(pwmc_q, wdata_q, wstrb_q);
      if (wr_irqmsk) irq_msk_q <= msk_merged[IRQ_W-1:0];
    end
  end

  // Sticky events, set wins over a one written to clear
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      irq_st_q <= '0;
      flags_q  <= '0;
    end else begin
      irq_st_q <= (irq_st_q & ~(wr_irqst ? w1c_bits[IRQ_W-1:0] : '0)) | evt;
      flags_q  <= MOTOR_IN.drv_flags;
    end
  end

  // R7: Offset integrator on current
  // R6: Offset held within +-255
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      ofs_q <= '0;
    end else if (step_up) begin
      ofs_q <= ofs_q + 9'sh001;
    end else if (step_dn) begin
      ofs_q <= ofs_q - 9'sh001;
    end
  end

  // R11: Applied duty register
  // R8: Auto offset at rest, gradient in motion
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      duty_q     <= '0;
      auto_ofs_q <= '0;
      auto_grd_q <= '0;
    end else begin
      duty_q <= applied;
      if (MOTOR_IN.reg_strobe && MOTOR_IN.standstill) begin
        auto_ofs_q <= duty_q;
      end else if (MOTOR_IN.reg_strobe) begin
        auto_grd_q <= duty_q > auto_ofs_q ? duty_q - auto_ofs_q : 8'h00;
      end
    end
  end

  // R5: Duty scales the table currents
  cpwrb_phase_scaler u_scaler (
    .clk      (REF_CLK),
    .rst      (RST),
    .position (MOTOR_IN.microstep_position_counter),
    .duty     (duty_q),
    .phase_q  (PHASE_OUT)
  );

  // Outputs
  assign S_AXI_BVALID = bvalid_q;
  assign S_AXI_BRESP  = bresp_q;
  assign S_AXI_RVALID = rvalid_q;
  assign S_AXI_RDATA  = rdata_q;
  assign S_AXI_RRESP  = rresp_q;
  assign CHOP_CFG     = chop_q;
  assign PWM_CFG      = pwmc_q[21:0] & PWMC_MASK;
  assign DUTY         = duty_q;
  assign IRQ          = |(irq_st_q & irq_msk_q);

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  sequence s_full_write(logic [7:0] ix);
    wr_fire && wr_idx == ix && wstrb_q == 4'hF;
  endsequence
  sequence s_read_of(logic [7:0] ix);
    ar_hs && rd_idx == ix;
  endsequence

  a_chop_reset_val: assert property ($fell(RST) |-> chop_q == CHOP_RST) // R1
    else $error("Chopper config reset value wrong");
  a_chop_write_val: assert property (s_full_write(IDX_CHOP) |=> chop_q == $past(wdata_q)) // R1
    else $error("Chopper config write lost");
  a_status_read: assert property (s_read_of(IDX_DRVST) |=>
    S_AXI_RVALID && S_AXI_RDATA[15:0] == $past(MOTOR_IN.drv_flags)) // R2
    else $error("Status read does not show flags");
  a_pwmc_reset_val: assert property ($fell(RST) |-> pwmc_q == PWMC_RST) // R3
    else $error("PWM config reset value wrong");
  a_duty_readback: assert property (s_read_of(IDX_SCALE) |=>
    S_AXI_RDATA[7:0] == $past(duty_q) && S_AXI_RDATA[24:16] == $past(ofs_q)) // R4
    else $error("Amplitude readback mismatch");
  a_ofs_bounds: assert property (ofs_q >= OFS_MIN && ofs_q <= OFS_MAX) // R6
    else $error("Regulation offset out of range");
  a_reg_step_up: assert property (MOTOR_IN.reg_strobe && want_up && ofs_q < OFS_MAX |=>
    ofs_q == $past(ofs_q) + 9'sh001) // R7
    else $error("Regulator did not step up");
  a_auto_capture: assert property (MOTOR_IN.reg_strobe && MOTOR_IN.standstill |=>
    auto_ofs_q == $past(duty_q)) // R8
    else $error("Auto offset not captured at rest");
  a_duty_clamp: assert property (clip_lo |=> duty_q == 8'h00) // R11
    else $error("Negative duty not clamped to zero");
  a_duty_no_ofs: assert property (ofs_q == 9'sh000 |=> duty_q == $past(calc_duty)) // R11
    else $error("Duty differs from calculated value");
  a_set_wins: assert property (evt[IRQ_CLIP] && wr_irqst |=> // R11
    irq_st_q[IRQ_CLIP] && (IRQ || !irq_msk_q[IRQ_CLIP]))
    else $error("Event lost under clear");
endmodule
`default_nettype wire

// ### tb/cpwrb_motor_model.sv
// Purpose: Motor side stand-in that drives the bank's motor inputs
// Assumes: Sensed coil current follows the applied duty one for one
// Notes:   Stuck mode pins the sensed current at full scale
`default_nettype none
module cpwrb_motor_model
  import cpwrb_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic [7:0]            duty,
  input  wire logic [7:0]            target,
  input  wire logic [9:0]            pos,
  input  wire logic [15:0]           flags,
  input  wire logic                  still,
  input  wire logic                  stuck,
  input  wire logic                  tick_en,
  output cpwrb_pkg::cpwrb_motor_in_t motor
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt_q;  // Spacing of regulation ticks
  logic [7:0] meas;   // Sensed current
  // Tick spacing, one strobe every fourth cycle
  always_ff @(posedge clk) begin
    if (!tick_en) cnt_q <= 2'h0;
    else cnt_q <= cnt_q + 2'h1;
  end
  // Sensed current, stuck high when commanded
  assign meas = stuck ? 8'hFF : duty;
  // Whole bundle, velocity held at zero
  assign motor = '{meas_current: meas, target_current: target, velocity: 8'h00,
                   microstep_position_counter: pos, drv_flags: flags, standstill: still,
                   reg_strobe: tick_en && (cnt_q == 2'h3)};
endmodule
`default_nettype wire

// ### tb/cpwrb_bank_tb.sv
// Purpose: Self-checking bench for the chopper and PWM register bank
// Assumes: One write and one read at a time over AXI4-Lite
// Notes:   Motor side comes from the stand-in model
`default_nettype none
module cpwrb_bank_tb
  import cpwrb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic            clk, rst;                          // Clock and reset
  logic [9:0]      awaddr, araddr;                    // Byte addresses
  logic            awvalid, wvalid, bready;           // Write side strobes
  logic            arvalid, rready;                   // Read side strobes
  logic            awready, wready, bvalid;           // Write answers
  logic            arready, rvalid, irq;              // Read answer, interrupt
  logic [31:0]     wdata, rdata, chop;                // Data words
  logic [3:0]      wstrb;                             // Byte lanes
  logic [1:0]      bresp, rresp, resp;                // Response codes
  logic [21:0]     pwmc;                              // PWM config port
  logic [7:0]      duty, target;                      // Duty and wanted current
  logic [9:0]      pos;                               // Wave position
  logic [15:0]     flags;                             // Driver flags
  logic            still, stuck, tick_en;             // Motor side controls
  logic [31:0]     word;                              // Last read word
  logic [8:0]      b_seen;                            // Saved phase B
  cpwrb_motor_in_t motor;                             // Motor bundle
  cpwrb_phase_t    phase;                             // Scaled phases
  int              errors, checked;                   // Tallies
  // Device under test
  cpwrb_bank uut (.REF_CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .MOTOR_IN(motor),
    .CHOP_CFG(chop), .PWM_CFG(pwmc), .DUTY(duty), .PHASE_OUT(phase), .IRQ(irq));
  // Motor side stand-in
  cpwrb_motor_model model (.clk(clk), .duty(duty), .target(target), .pos(pos), .flags(flags),
    .still(still), .stuck(stuck), .tick_en(tick_en), .motor(motor));
  // Free running clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Verdict and end of run
  task automatic conclude();
    if (errors == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Single compare point
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Bus wait ran out
  task automatic hung();
    errors++;
    $display("[FAIL] bus answer expected 1 seen 0");
    conclude();
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Write, address and data offered together
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    bit done;
    done = 1'b0;
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    for (int n = 0; n < 50 && !done; n++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        resp = bresp;
        done = 1'b1;
      end
    end
    if (!done) hung();
  endtask
  // Read one word
  task automatic rd(input logic [9:0] a);
    bit done;
    done = 1'b0;
    araddr  <= a;
    arvalid <= 1'b1;
    for (int n = 0; n < 50 && !done; n++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        word = rdata;
        resp = rresp;
        done = 1'b1;
      end
    end
    if (!done) hung();
  endtask
  task automatic rdc(input string nm, input logic [9:0] a, input logic [31:0] e);
    rd(a);
    chk(nm, e, word);
  endtask
  task automatic t_reset();
    rdc("chop reset", 10'h1B0, 32'h10000053);
    rdc("pwm reset", 10'h1C0, 32'h000D0024);
    chk("pwm port", 32'h000D0024, {10'h000, pwmc});
    rdc("mask reset", 10'h1D0, 32'h0);
  endtask
  task automatic t_regs();
    wstrb <= 4'h5;
    wr(10'h1B0, 32'hAABBCCDD);
    wstrb <= 4'hF;
    chk("chop port", 32'h10BB00DD, chop);
    rdc("chop lanes", 10'h1B0, 32'h10BB00DD);
    wr(10'h1B0, 32'h12345678);
    chk("chop full", 32'h12345678, chop);
    wr(10'h1C0, 32'hFFFFFFFF);
    rdc("pwm width", 10'h1C0, 32'h003FFFFF);
    wr(10'h1C4, 32'h0);
    chk("ro resp", 32'h0, {30'h0, resp});
    rdc("ro keeps", 10'h1C4, 32'h000000FF);
    wr(10'h3FC, 32'h1);
    chk("hole wr resp", 32'h2, {30'h0, resp});
    rdc("hole rd", 10'h3FC, 32'h0);
    chk("hole rd resp", 32'h2, {30'h0, resp});
  endtask
  task automatic t_regulate();
    wr(10'h1C0, 32'hC1000040);
    target  <= 8'h50;
    tick_en <= 1'b1;
    cyc(160);
    tick_en <= 1'b0;
    cyc(3);
    chk("duty up", 32'h50, {24'h0, duty});
    rdc("offset up", 10'h1C4, 32'h00100050);
    target  <= 8'h30;
    tick_en <= 1'b1;
    cyc(240);
    tick_en <= 1'b0;
    cyc(3);
    rdc("offset down", 10'h1C4, 32'h01F00030);
  endtask
  task automatic t_auto();
    still   <= 1'b1;
    tick_en <= 1'b1;
    cyc(4);
    still   <= 1'b0;
    tick_en <= 1'b0;
    wr(10'h1C0, 32'hC1000090);
    target <= 8'h80;
    cyc(3);
    tick_en <= 1'b1;
    cyc(4);
    tick_en <= 1'b0;
    rdc("auto word", 10'h1C8, 32'h00500030);
    wr(10'h1C0, {16'h0, word[23:16], word[7:0]});
    chk("seeded cfg", 32'h00005030, {10'h000, pwmc});
  endtask
  task automatic t_phase();
    pos <= 10'h040;
    cyc(3);
    b_seen = phase.phase_b;
    pos <= 10'h140;
    cyc(3);
    chk("phase lead", {23'h0, b_seen}, {23'h0, phase.phase_a});
  endtask
  task automatic t_status();
    wr(10'h1CC, 32'h7);
    flags <= 16'hA5A5;
    cyc(3);
    rdc("driver_status_flags", 10'h1BC, 32'h0004A5A5);
    rdc("flag event", 10'h1CC, 32'h4);
    wr(10'h1CC, 32'h4);
    rdc("flag clear", 10'h1CC, 32'h0);
  endtask
  task automatic t_floor();
    target  <= 8'h00;
    stuck   <= 1'b1;
    tick_en <= 1'b1;
    cyc(1100);
    tick_en <= 1'b0;
    cyc(3);
    chk("duty floor", 32'h0, {24'h0, duty});
    chk("phase zero", 32'h0, {14'h0, phase});
    rdc("offset floor", 10'h1C4, 32'h01010000);
    rdc("irq status", 10'h1CC, 32'h3);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(10'h1D0, 32'h2);
    chk("irq open", 32'h1, {31'h0, irq});
    // Clear both; clipping still active so its bit must survive
    wr(10'h1CC, 32'h3);
    chk("irq cleared", 32'h0, {31'h0, irq});
    rdc("clip sticky", 10'h1CC, 32'h1);
  endtask
  // Main sequence
  initial begin
    errors  = 0;
    checked = 0;
    rst     = 1'b1;
    {awaddr, araddr, wdata, pos, flags, target} = '0;
    {awvalid, wvalid, arvalid, still, stuck, tick_en} = '0;
    wstrb   = 4'hF;
    bready  = 1'b1;
    rready  = 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_regs();
    t_regulate();
    t_auto();
    t_phase();
    t_status();
    t_floor();
    conclude();
  end
endmodule
`default_nettype wire
